// ---- rtl/eirp_ext_irq_regs.sv ----
// module: external request flags, enables, sense select and priority group b registers
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - priority group b is 8-bit read/write, zero after reset or standby.
// - bit 7 sets timer channel 3 priority high when one.
// - bit 6 sets timer channel 4 priority high when one.
// - bits 3 and 2 set serial channel 0 and 1 priorities.
// - bit 1 sets converter priority high when one.
// - priority bits 5, 4, 0 ignore writes and read zero.
// - status bits 5, 4, 1, 0 flag pending requests per source.
// - a written one never sets a request flag.
// - a zero write clears a flag only after it was read as one.
// - level mode: exception handling clears flag only if pin is high.
// - edge mode: exception handling clears the flag unless a new falling edge sets it in the same cycle.
// - level mode: flag sets while the pin is low.
// - edge mode: flag sets on a high to low pin change.
// - status bits 7, 6, 3, 2 ignore writes and read zero.
// - status clears to zero on reset and standby.
// - enable bits 5, 4, 1, 0 enable their sources, default off.
// - enable bits 7, 6, 3, 2 ignore writes and read zero.
// - enable register zero after reset and standby.
// - sense bits 5, 4, 1, 0: zero level, one falling edge.
// - sense bits 7, 6, 3, 2 store and read back, no effect.
// - sense register zero after reset and standby.
// - pins are sensed whatever their port direction.
module eirp_ext_irq_regs
    import eirp_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 hw_standby_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [EIRP_AW-1:0]   wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [EIRP_NSRC-1:0] ext_request_pin_n_i,
    input  wire logic [EIRP_NSRC-1:0] exc_handled_i,
    output logic      [EIRP_NSRC-1:0] ext_request_o,
    output logic      [EIRP_NSRC-1:0] ext_request_prio_o,
    output logic                      timer_ch3_priority_o,
    output logic                      timer_ch4_priority_o,
    output logic                      serial_ch0_priority_o,
    output logic                      serial_ch1_priority_o,
    output logic                      adc_priority_o
);

    ////////////////////////////////////////////////////////////////////////
    // external priority level per source, tied to zero; no group a register input feeds it
    ////////////////////////////////////////////////////////////////////////
    logic [EIRP_NSRC-1:0] src_prio_in;
    assign src_prio_in = '0;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    ////////////////////////////////////////////////////////////////////////
    logic       clr_all;
    logic       acc_new;
    logic       wr_strobe;
    logic       rd_strobe;
    logic       sel_prio;
    logic       sel_stat;
    logic       sel_en;
    logic       sel_sense;
    logic [7:0] wdat;

    assign clr_all   = rst_i | hw_standby_i;
    assign acc_new   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_strobe = acc_new & wb_we_i & wb_sel_i[0];
    assign rd_strobe = acc_new & ~wb_we_i;
    assign sel_prio  = (wb_adr_i == EIRP_OFF_PRIO_B);
    assign sel_stat  = (wb_adr_i == EIRP_OFF_STATUS);
    assign sel_en    = (wb_adr_i == EIRP_OFF_ENABLE);
    assign sel_sense = (wb_adr_i == EIRP_OFF_SENSE);
    assign wdat      = wb_dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] prio_b_q;
    logic [7:0] enable_q;
    logic [7:0] sense_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] armed_q;
    logic [7:0] armed_d;
    logic [7:0] pin_prev_q;

    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            prio_b_q <= EIRP_RST_VAL;
            enable_q <= EIRP_RST_VAL;
            sense_q  <= EIRP_RST_VAL;
        end else if (wr_strobe) begin
            if (sel_prio) prio_b_q <= wdat & EIRP_PRIO_B_MASK;
            if (sel_en) enable_q <= wdat & EIRP_SRC_MASK;
            if (sel_sense) sense_q <= wdat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-source flag logic
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [7:0] pin_low;
    logic [EIRP_NSRC-1:0] req_d;

    generate
        for (genvar s = 0; s < EIRP_NSRC; s++) begin : g_src
            localparam int P = EIRP_SRC_POS[s];
            // pins are sensed directly, port direction plays no part
            assign pin_low[P] = ~ext_request_pin_n_i[s];
            // level: set while low; edge: set on high to low
            assign set_ev[P] = sense_q[P] ? (pin_low[P] & ~pin_prev_q[P])
                                          : pin_low[P];
            assign clr_ev[P] =
                (exc_handled_i[s] & (sense_q[P] | ~pin_low[P]))
                | (wr_strobe & sel_stat & ~wdat[P] & armed_q[P]);
            assign req_d[s] = status_q[P] & enable_q[P];
        end
        for (genvar r = 0; r < 8; r++) begin : g_pad
            if (!EIRP_SRC_MASK[r]) begin : g_rsv
                assign pin_low[r] = 1'b0;
                assign set_ev[r]  = 1'b0;
                assign clr_ev[r]  = 1'b0;
            end
        end
    endgenerate

    // set wins over clear; reserved bits stay zero
    assign status_d = ((status_q & ~clr_ev) | set_ev) & EIRP_SRC_MASK;
    // a read of one arms the clear; any status write with byte lane 0 selected disarms
    assign armed_d  = (rd_strobe & sel_stat) ? (armed_q | status_q)
                    : (wr_strobe & sel_stat) ? 8'h00 : (armed_q & status_q);

    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            status_q   <= EIRP_RST_VAL;
            armed_q    <= EIRP_RST_VAL;
            pin_prev_q <= EIRP_RST_VAL;
        end else begin
            status_q   <= status_d;
            armed_q    <= armed_d;
            pin_prev_q <= pin_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux, ack and registered outputs
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] rd_mux;
    assign rd_mux = sel_prio  ? prio_b_q
                  : sel_stat  ? status_q
                  : sel_en    ? enable_q
                  : sel_sense ? sense_q : 8'h00;

    // requests and their level leave through flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_request_o      <= '0;
            ext_request_prio_o <= '0;
        end else begin
            ext_request_o      <= req_d;
            ext_request_prio_o <= src_prio_in;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= acc_new;
            wb_dat_o <= rd_strobe ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr_all) begin
            timer_ch3_priority_o  <= 1'b0;
            timer_ch4_priority_o  <= 1'b0;
            serial_ch0_priority_o <= 1'b0;
            serial_ch1_priority_o <= 1'b0;
            adc_priority_o        <= 1'b0;
        end else begin
            timer_ch3_priority_o  <= prio_b_q[EIRP_TMR3_BIT];
            timer_ch4_priority_o  <= prio_b_q[EIRP_TMR4_BIT];
            serial_ch0_priority_o <= prio_b_q[EIRP_SER0_BIT];
            serial_ch1_priority_o <= prio_b_q[EIRP_SER1_BIT];
            adc_priority_o        <= prio_b_q[EIRP_ADC_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    prio_rsv_zero_a: assert property (prio_b_q[5:4] == 2'b00 && !prio_b_q[0])
        else $error("reserved priority bits not zero");
    stat_rsv_zero_a: assert property ((status_q & ~EIRP_SRC_MASK) == 8'h00)
        else $error("reserved status bits not zero");
    en_rsv_zero_a: assert property ((enable_q & ~EIRP_SRC_MASK) == 8'h00)
        else $error("reserved enable bits not zero");
    standby_clear_a: assert property (hw_standby_i |=> status_q == 8'h00 && sense_q == 8'h00
        && enable_q == 8'h00 && prio_b_q == 8'h00)
        else $error("standby did not clear registers");
    level_set_a: assert property (!hw_standby_i && !sense_q[0] && !ext_request_pin_n_i[0]
        |=> status_q[0])
        else $error("level request not flagged");
    edge_set_a: assert property (!hw_standby_i && sense_q[1] && !ext_request_pin_n_i[1]
        && !pin_prev_q[1] |=> status_q[1])
        else $error("falling edge not flagged");
    no_arm_clear_a: assert property (wr_strobe && sel_stat && !armed_q[0] && status_q[0]
        && !hw_standby_i |=> status_q[0])
        else $error("flag cleared without prior read");
    edge_exc_clr_a: assert property (!hw_standby_i && sense_q[4] && status_q[4]
        && exc_handled_i[2] && !set_ev[4] |=> !status_q[4])
        else $error("edge flag not cleared by handling");
    level_keep_a: assert property (!hw_standby_i && !sense_q[5] && !ext_request_pin_n_i[3]
        && exc_handled_i[3] |=> status_q[5])
        else $error("level flag cleared while pin low");
    req_gate_a: assert property (ext_request_o[0] == $past(status_q[0] && enable_q[0]))
        else $error("request not gated by enable");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    read_clear_c: cover property (rd_strobe && sel_stat && status_q[0] ##[1:4]
        (wr_strobe && sel_stat && !wdat[0]));
    edge_req_c: cover property (sense_q[1] && set_ev[1]);
    exc_clear_c: cover property (exc_handled_i[0] && status_q[0]);

endmodule
`default_nettype wire

// ---- rtl/eirp_pkg.sv ----
// package: register map, field positions and reset values for the external request block
package eirp_pkg;
    localparam int          EIRP_DW           = 8;
    localparam int          EIRP_AW           = 4;
    localparam logic [3:0]  EIRP_OFF_PRIO_B   = 4'h0;
    localparam logic [3:0]  EIRP_OFF_STATUS   = 4'h4;
    localparam logic [3:0]  EIRP_OFF_ENABLE   = 4'h8;
    localparam logic [3:0]  EIRP_OFF_SENSE    = 4'hC;
    localparam logic [7:0]  EIRP_RST_VAL      = 8'h00;
    localparam logic [7:0]  EIRP_PRIO_B_MASK  = 8'hCE;
    localparam logic [7:0]  EIRP_SRC_MASK     = 8'h33;
    localparam int          EIRP_TMR3_BIT     = 7;
    localparam int          EIRP_TMR4_BIT     = 6;
    localparam int          EIRP_SER0_BIT     = 3;
    localparam int          EIRP_SER1_BIT     = 2;
    localparam int          EIRP_ADC_BIT      = 1;
    localparam int          EIRP_NSRC         = 4;
    // source index -> bit position in status, enable and sense registers
    localparam int          EIRP_SRC_POS [4]  = '{0, 1, 4, 5};
endpackage

// ---- testbench/eirp_ext_irq_regs_tb.sv ----
// bench: register, flag and request checks for the external request block
`timescale 1ns/1ps
`default_nettype none
module eirp_ext_irq_regs_tb
    import eirp_pkg::*;
();
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        stby  = 0;
    logic        cyc   = 0;
    logic        stb   = 0;
    logic        we    = 0;
    logic [3:0]  adr   = 4'h0;
    logic [3:0]  sel   = 4'hF;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  lvl   = 4'h0;
    logic [3:0]  pin_n;
    logic [3:0]  exc   = 4'h0;
    logic [3:0]  req;
    logic [3:0]  prio;
    logic [4:0]  pouts;
    int          mismatches = 0;
    int          total_checks = 0;
    logic [31:0] r;
    always #25 clk_i = ~clk_i;
    eirp_pin_driver eirp_pin_driver_i (.clk_i(clk_i), .pull_low_i(lvl), .pin_n_o(pin_n));
    eirp_ext_irq_regs eirp_ext_irq_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .hw_standby_i(stby), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_request_pin_n_i(pin_n), .exc_handled_i(exc),
        .ext_request_o(req), .ext_request_prio_o(prio), .timer_ch3_priority_o(pouts[4]),
        .timer_ch4_priority_o(pouts[3]), .serial_ch0_priority_o(pouts[2]),
        .serial_ch1_priority_o(pouts[1]), .adc_priority_o(pouts[0]));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // classic single cycle, held until ack sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        wb(1'b0, a, 8'h00);
        chk(nm, {24'h0, e}, r);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clk_i); exc <= m;
        @(posedge clk_i); exc <= 4'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(EIRP_OFF_PRIO_B, 8'h00, "prio reset");
        rd(EIRP_OFF_STATUS, 8'h00, "status reset");
        rd(EIRP_OFF_ENABLE, 8'h00, "enable reset");
        rd(EIRP_OFF_SENSE, 8'h00, "sense reset");
        wb(1'b1, EIRP_OFF_PRIO_B, 8'hFF);
        rd(EIRP_OFF_PRIO_B, 8'hCE, "prio reserved");
        chk("prio outs all", 32'h1F, {27'h0, pouts});
        wb(1'b1, EIRP_OFF_PRIO_B, 8'h44);
        rd(EIRP_OFF_PRIO_B, 8'h44, "prio rw");
        chk("prio outs some", 32'h0A, {27'h0, pouts});
        wb(1'b1, EIRP_OFF_ENABLE, 8'hFF);
        rd(EIRP_OFF_ENABLE, 8'h33, "enable mask");
        wb(1'b1, EIRP_OFF_STATUS, 8'hFF);
        rd(EIRP_OFF_STATUS, 8'h00, "status ones");
        wb(1'b1, EIRP_OFF_SENSE, 8'hFC);
        rd(EIRP_OFF_SENSE, 8'hFC, "sense rw");
        rd(4'h2, 8'h00, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_level();
        lvl <= 4'h1;
        repeat (4) @(posedge clk_i);
        lvl <= 4'h0;
        repeat (3) @(posedge clk_i);
        wb(1'b1, EIRP_OFF_STATUS, 8'h00);
        rd(EIRP_OFF_STATUS, 8'h01, "unread clear");
        chk("request", 32'h1, {28'h0, req});
        chk("request prio", 32'h0, {28'h0, prio});
        pulse(4'h1);
        rd(EIRP_OFF_STATUS, 8'h00, "level handled");
        $display("test level done");
    endtask
    task automatic t_edge();
        wb(1'b1, EIRP_OFF_SENSE, 8'hFE);
        lvl <= 4'h2;
        repeat (4) @(posedge clk_i);
        rd(EIRP_OFF_STATUS, 8'h02, "edge set");
        wb(1'b1, EIRP_OFF_STATUS, 8'h00);
        rd(EIRP_OFF_STATUS, 8'h00, "read clear");
        lvl <= 4'h0;
        repeat (3) @(posedge clk_i);
        lvl <= 4'h2;
        repeat (4) @(posedge clk_i);
        pulse(4'h2);
        rd(EIRP_OFF_STATUS, 8'h00, "edge handled");
        lvl <= 4'h0;
        @(posedge clk_i); stby <= 1'b1;
        @(posedge clk_i); stby <= 1'b0;
        rd(EIRP_OFF_SENSE, 8'h00, "sense standby");
        rd(EIRP_OFF_ENABLE, 8'h00, "enable standby");
        rd(EIRP_OFF_PRIO_B, 8'h00, "prio standby");
        rd(EIRP_OFF_STATUS, 8'h00, "status standby");
        $display("test edge done");
    endtask
    task automatic t_high();
        sel <= 4'hE;
        wb(1'b1, EIRP_OFF_ENABLE, 8'hFF);
        sel <= 4'hF;
        rd(EIRP_OFF_ENABLE, 8'h00, "enable sel off");
        wb(1'b1, EIRP_OFF_ENABLE, 8'h30);
        wb(1'b1, EIRP_OFF_SENSE, 8'h10);
        lvl <= 4'h8;
        repeat (3) @(posedge clk_i);
        pulse(4'h8);
        rd(EIRP_OFF_STATUS, 8'h20, "level kept");
        chk("request high", 32'h8, {28'h0, req});
        lvl <= 4'h4;
        repeat (3) @(posedge clk_i);
        pulse(4'h4);
        rd(EIRP_OFF_STATUS, 8'h20, "edge src handled");
        wb(1'b1, EIRP_OFF_STATUS, 8'h00);
        rd(EIRP_OFF_STATUS, 8'h00, "high read clear");
        chk("request gone", 32'h0, {28'h0, req});
        lvl <= 4'h0;
        $display("test high done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_level();
        t_edge();
        t_high();
        give_verdict();
    end
endmodule
`default_nettype wire

// ---- testbench/eirp_pin_driver.sv ----
// model: external devices pulling the active-low request pins
`timescale 1ns/1ps
`default_nettype none
module eirp_pin_driver (
    input  wire logic       clk_i,
    input  wire logic [3:0] pull_low_i,
    output logic      [3:0] pin_n_o
);
    // pins idle high through pull-ups until a device pulls low
    always @(posedge clk_i) begin
        pin_n_o <= ~pull_low_i;
    end
endmodule
`default_nettype wire
